//--- design/ppss_deb_if.sv
// interface: one debounced active-low input toward the sequencer
`timescale 1ns/1ps
interface ppss_deb_if;
   logic enable;
   logic event_pulse;
   modport filt (input enable, output event_pulse);
   modport user (output enable, input event_pulse);
endinterface

//--- design/ppss_debounce.sv
// module: synchroniser and low-period debounce with release event
`timescale 1ns/1ps
module ppss_debounce
   import ppss_pkg::*;
#(
   parameter int unsigned LOW_CYC = DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // pin and carrier
   input  wire logic pin_n,
   ppss_deb_if.filt  dif
);
   typedef struct packed {
      logic             s1;
      logic             s2;
      logic             armed;
      logic [CNT_W-1:0] cnt;
      logic             pulse;
   } ppss_deb_t;

   ppss_deb_t st_ff;
   ppss_deb_t nxt_st;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.s1    = pin_n;
      nxt_st.s2    = st_ff.s1;
      nxt_st.pulse = 1'b0;
      if (!dif.enable) begin
         nxt_st.cnt   = CNT_RST;
         nxt_st.armed = 1'b0;
      end else if (!st_ff.s2) begin
         // count the low period, saturating once long enough
         if (st_ff.cnt >= LOW_CYC[CNT_W-1:0] - 1'b1) begin
            nxt_st.armed = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end else begin
         // short lows are dropped: only a long low then high counts
         nxt_st.pulse = st_ff.armed;
         nxt_st.armed = 1'b0;
         nxt_st.cnt   = CNT_RST;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '{s1: 1'b1, s2: 1'b1, armed: 1'b0, cnt: CNT_RST, pulse: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dif.event_pulse = st_ff.pulse;
endmodule

//--- design/ppss_pkg.sv
// package: constants and types of the platform power state signalling block
package ppss_pkg;

   // timing figures as printed and derived cycle counts at 200 MHz
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned RSM_HOLD_MS      = 5;
   localparam int unsigned DEBOUNCE_MS      = 16;
   localparam int unsigned HOT_HOLD_US      = 500;
   localparam int unsigned RSM_HOLD_CYC     = RSM_HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int unsigned HOT_HOLD_CYC     = HOT_HOLD_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 24;
   localparam int unsigned SEQ_STEP_CYC     = 16;

   // default three-bit power mode codes
   localparam logic [2:0]  PM_OFF_DEF       = 3'h0;
   localparam logic [2:0]  PM_COLD_DEF      = 3'h1;
   localparam logic [2:0]  PM_WARM_DEF      = 3'h2;
   localparam logic [2:0]  PM_RUN_DEF       = 3'h3;
   localparam logic [2:0]  PM_SLEEP_DEF     = 3'h4;

   // reset values
   localparam logic [CNT_W-1:0] CNT_RST     = 24'h000000;
   localparam logic [3:0]  EVT_RST          = 4'h0;

   // event bit positions
   localparam int unsigned EV_TEMP          = 0;
   localparam int unsigned EV_UNDER         = 1;
   localparam int unsigned EV_OVER          = 2;
   localparam int unsigned EV_BUTTON        = 3;

   typedef enum logic [3:0] {
      PPSS_OFF,
      PPSS_S45,
      PPSS_S3,
      PPSS_RUN_UP,
      PPSS_S0,
      PPSS_WARN,
      PPSS_WARM,
      PPSS_TRIP
   } ppss_state_t;

endpackage

//--- design/ppss_top.sv
// module: platform power state and reset signalling sequencer
`timescale 1ns/1ps
module ppss_top
   import ppss_pkg::*;
#(
   parameter logic [2:0]  PM_OFF   = PM_OFF_DEF,
   parameter logic [2:0]  PM_COLD  = PM_COLD_DEF,
   parameter logic [2:0]  PM_WARM  = PM_WARM_DEF,
   parameter logic [2:0]  PM_RUN   = PM_RUN_DEF,
   parameter logic [2:0]  PM_SLEEP = PM_SLEEP_DEF,
   parameter int unsigned RSM_CYC  = RSM_HOLD_CYC,
   parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
   parameter int unsigned HOT_CYC  = HOT_HOLD_CYC
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // configuration straps and internal status
   input  wire logic       hub_variant_third_party,
   input  wire logic       push_button_enable,
   input  wire logic       resume_supplies_valid,
   input  wire logic       main_supplies_stable,
   input  wire logic       hub_supplies_stable,
   input  wire logic       junction_hot,
   input  wire logic       over_temp_evt,
   input  wire logic       under_volt_evt,
   input  wire logic       over_volt_evt,
   input  wire logic [3:0] irq_mask,
   input  wire logic [3:0] irq_clear,
   // platform pins in
   input  wire logic       power_button_n,
   input  wire logic       wake_n,
   input  wire logic       reset_in_n,
   input  wire logic       sleep_type_select,
   input  wire logic       sleep_ready_n,
   input  wire logic       reset_ready_n,
   input  wire logic       hub_power_ok_enable,
   input  wire logic       thermal_trip_n,
   input  wire logic [6:0] voltage_code,
   input  wire logic [1:0] voltage_code_domain_select,
   // platform pins out
   output logic            processor_reset_n,
   output logic            supplies_good,
   output logic            resume_domain_reset_n,
   output logic            reset_warning,
   output logic            irq_n_out,
   output logic            irq_n_oe,
   output logic            processor_hot_n_out,
   output logic            processor_hot_n_oe,
   output logic [2:0]      power_mode_bus,
   output logic            memory_io_switch_ctrl,
   output logic            hub_plane_a_reset_n,
   output logic            hub_plane_b_reset_n,
   output logic            hub_plane_c_reset_n,
   output logic            hub_plane_b_sleep_n,
   output logic            hub_plane_c_sleep_n,
   output logic            hub_supplies_good,
   // status toward the supply logic
   output logic            platform_power_on,
   output logic [3:0]      irq_status,
   output logic [6:0]      core_voltage_code,
   output logic [6:0]      graphics_voltage_code
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   localparam int unsigned NSYNC = 15;

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;

   assign raw_in = {voltage_code_domain_select, voltage_code, sleep_type_select, sleep_ready_n,
                    reset_ready_n, hub_power_ok_enable, thermal_trip_n, power_button_n};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               sync1_ff[gi] <= 1'b1;
               sync2_ff[gi] <= 1'b1;
            end else begin
               sync1_ff[gi] <= raw_in[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   logic       pbtn_s;
   logic       trip_n_s;
   logic       pok_en_s;
   logic       rst_rdy_n_s;
   logic       slp_rdy_n_s;
   logic       slp_type_s;
   logic [6:0] vcode_s;
   logic [1:0] vsel_s;

   // active-low pins kept as sampled, except the power button, which is inverted into pbtn_s
   assign pbtn_s      = ~sync2_ff[0];
   assign trip_n_s    = sync2_ff[1];
   assign pok_en_s    = sync2_ff[2];
   assign rst_rdy_n_s = sync2_ff[3];
   assign slp_rdy_n_s = sync2_ff[4];
   assign slp_type_s  = sync2_ff[5];
   assign vcode_s     = sync2_ff[12:6];
   assign vsel_s      = sync2_ff[14:13];

   ////////////////////////////////////////////////////////////////////////
   // debounced wake and warm reset
   ppss_deb_if wake_if ();
   ppss_deb_if rin_if ();

   ppss_debounce #(.LOW_CYC(DEB_CYC)) u_wake_deb (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin_n   (wake_n),
      .dif     (wake_if.filt)
   );

   ppss_debounce #(.LOW_CYC(DEB_CYC)) u_rin_deb (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin_n   (reset_in_n),
      .dif     (rin_if.filt)
   );

   ////////////////////////////////////////////////////////////////////////
   // state and registered outputs
   typedef struct packed {
      ppss_state_t      state;
      logic [CNT_W-1:0] rsm_cnt;
      logic             rsm_rel;
      logic [CNT_W-1:0] step_cnt;
      logic [CNT_W-1:0] hot_cnt;
      logic             hot;
      logic [3:0]       pend;
      logic             pbtn_d;
      logic             slp_rdy_d;
      logic             warn_req;
      logic [6:0]       core_v;
      logic [6:0]       gfx_v;
   } ppss_top_t;

   ppss_top_t st_ff;
   ppss_top_t nxt_st;

   function automatic logic in_sleep(input ppss_state_t s);
      in_sleep = (s == PPSS_OFF) || (s == PPSS_S45) || (s == PPSS_S3) || (s == PPSS_TRIP);
   endfunction

   logic       pbtn_evt;
   logic [3:0] evt_new;

   assign wake_if.enable = (st_ff.state == PPSS_S3) || (st_ff.state == PPSS_S45);
   assign rin_if.enable  = (st_ff.state == PPSS_S0);
   assign pbtn_evt       = pbtn_s && !st_ff.pbtn_d;
   assign evt_new[EV_TEMP]   = over_temp_evt;
   assign evt_new[EV_UNDER]  = under_volt_evt;
   assign evt_new[EV_OVER]   = over_volt_evt;
   assign evt_new[EV_BUTTON] = pbtn_evt && push_button_enable &&
                               ((st_ff.state == PPSS_S0) || (st_ff.state == PPSS_S3));

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.pbtn_d    = pbtn_s;
      nxt_st.slp_rdy_d = slp_rdy_n_s;
      // set wins over a clear in the same cycle
      nxt_st.pend = (st_ff.pend & ~irq_clear) | evt_new;
      // voltage code latched per selected domain
      if (vsel_s[0]) begin
         nxt_st.core_v = vcode_s;
      end
      if (vsel_s[1]) begin
         nxt_st.gfx_v = vcode_s;
      end
      // processor hot with minimum low time
      if (junction_hot) begin
         nxt_st.hot     = 1'b1;
         nxt_st.hot_cnt = CNT_RST;
      end else if (st_ff.hot) begin
         if (st_ff.hot_cnt >= HOT_CYC[CNT_W-1:0] - 1'b1) begin
            nxt_st.hot = 1'b0;
         end else begin
            nxt_st.hot_cnt = st_ff.hot_cnt + 1'b1;
         end
      end
      // resume reset release after supplies valid long enough
      if (!resume_supplies_valid) begin
         nxt_st.rsm_cnt = CNT_RST;
         nxt_st.rsm_rel = 1'b0;
      end else if (st_ff.rsm_cnt >= RSM_CYC[CNT_W-1:0] - 1'b1) begin
         nxt_st.rsm_rel = 1'b1;
      end else begin
         nxt_st.rsm_cnt = st_ff.rsm_cnt + 1'b1;
      end
      if ((pbtn_evt && st_ff.state == PPSS_S0) || over_temp_evt) begin
         nxt_st.warn_req = 1'b1;
      end
      nxt_st.step_cnt = CNT_RST;
      case (st_ff.state)
         PPSS_OFF: begin
            if (st_ff.rsm_rel) begin
               nxt_st.state = PPSS_S45;
            end
         end
         PPSS_S45, PPSS_S3: begin
            // wake or a button press starts the run-up
            if (wake_if.event_pulse || pbtn_evt) begin
               nxt_st.state = PPSS_RUN_UP;
            end else if (st_ff.state == PPSS_S45 && slp_type_s) begin
               nxt_st.state = PPSS_S45;
            end
         end
         PPSS_RUN_UP: begin
            nxt_st.step_cnt = st_ff.step_cnt + 1'b1;
            if (main_supplies_stable && (!hub_variant_third_party || pok_en_s) &&
                st_ff.step_cnt >= SEQ_STEP_CYC[CNT_W-1:0]) begin
               nxt_st.state    = PPSS_S0;
               nxt_st.warn_req = 1'b0;
            end
         end
         PPSS_S0: begin
            if (rin_if.event_pulse) begin
               nxt_st.state = PPSS_WARM;
            end else if (st_ff.warn_req || (slp_rdy_n_s && !st_ff.slp_rdy_d)) begin
               // deasserted sleep ready alone leaves the state at PPSS_S0; only warn_req moves to PPSS_WARN
               nxt_st.state = st_ff.warn_req ? PPSS_WARN : PPSS_S0;
            end
         end
         PPSS_WARN: begin
            if (!rst_rdy_n_s) begin
               nxt_st.warn_req = 1'b0;
               nxt_st.state    = slp_type_s ? PPSS_S3 : PPSS_S45;
            end
         end
         PPSS_WARM: begin
            nxt_st.step_cnt = st_ff.step_cnt + 1'b1;
            if (st_ff.step_cnt >= SEQ_STEP_CYC[CNT_W-1:0]) begin
               nxt_st.state = PPSS_S0;
            end
         end
         PPSS_TRIP: begin
            // latched until full reset: no return from a catastrophic trip
            nxt_st.state = PPSS_TRIP;
         end
         default: begin
            nxt_st.state = PPSS_OFF;
         end
      endcase
      if (!trip_n_s) begin
         nxt_st.state = PPSS_TRIP;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '{state: PPSS_OFF, rsm_cnt: CNT_RST, rsm_rel: 1'b0, step_cnt: CNT_RST,
                    hot_cnt: CNT_RST, hot: 1'b0, pend: EVT_RST, pbtn_d: 1'b0,
                    slp_rdy_d: 1'b1, warn_req: 1'b0, core_v: 7'h00, gfx_v: 7'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output decode
   logic s0_like;
   logic hub_s3_up;

   assign s0_like   = (st_ff.state == PPSS_S0) || (st_ff.state == PPSS_WARN) ||
                      (st_ff.state == PPSS_WARM);
   assign hub_s3_up = !in_sleep(st_ff.state) || (st_ff.state == PPSS_S3);

   assign processor_reset_n     = s0_like && (st_ff.state != PPSS_WARM);
   assign supplies_good         = s0_like;
   assign resume_domain_reset_n = st_ff.rsm_rel && (st_ff.state != PPSS_TRIP);
   assign reset_warning         = (st_ff.state == PPSS_WARN);
   assign irq_status            = st_ff.pend;
   assign irq_n_out             = 1'b0;
   assign irq_n_oe              = |(st_ff.pend & ~irq_mask);
   assign processor_hot_n_out   = 1'b0;
   assign processor_hot_n_oe    = st_ff.hot;
   assign memory_io_switch_ctrl = s0_like || (st_ff.state == PPSS_RUN_UP);
   assign hub_plane_a_reset_n   = (st_ff.state != PPSS_OFF) && (st_ff.state != PPSS_TRIP);
   assign hub_plane_b_reset_n   = hub_s3_up;
   assign hub_plane_c_reset_n   = s0_like;
   assign hub_plane_b_sleep_n   = hub_s3_up;
   assign hub_plane_c_sleep_n   = s0_like || (st_ff.state == PPSS_RUN_UP);
   assign hub_supplies_good     = s0_like && hub_supplies_stable;
   assign platform_power_on     = (st_ff.state != PPSS_TRIP) && (st_ff.state != PPSS_OFF);
   assign core_voltage_code     = st_ff.core_v;
   assign graphics_voltage_code = st_ff.gfx_v;

   always_comb begin
      case (st_ff.state)
         PPSS_RUN_UP: power_mode_bus = PM_COLD;
         PPSS_WARM:   power_mode_bus = PM_WARM;
         PPSS_S0,
         PPSS_WARN:   power_mode_bus = PM_RUN;
         PPSS_S3:     power_mode_bus = PM_SLEEP;
         default:     power_mode_bus = PM_OFF;
      endcase
   end

endmodule

//--- test/ppss_cpu_model.sv
// partner: processor and hub side of the platform handshakes
`timescale 1ns/1ps
module ppss_cpu_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // from the sequencer
   input  wire logic reset_warning,
   input  wire logic supplies_good,
   // bench control
   input  wire logic hub_ready,
   input  wire logic slow,
   input  wire logic trip_req,
   // toward the sequencer
   output logic      reset_ready_n,
   output logic      sleep_ready_n,
   output logic      hub_power_ok_enable,
   output logic      thermal_trip_n
);
   logic [3:0] wcnt_ff;
   // slow answer exercises the warning hold
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wcnt_ff             <= 4'h0;
         hub_power_ok_enable <= 1'b0;
      end else begin
         wcnt_ff             <= reset_warning ? wcnt_ff + {3'h0, wcnt_ff != 4'hf} : 4'h0;
         // hub grants the run-up only once its own side is ready
         hub_power_ok_enable <= hub_ready;
      end
   end
   assign reset_ready_n  = !(reset_warning && wcnt_ff >= (slow ? 4'h6 : 4'h1));
   assign sleep_ready_n  = !supplies_good;
   assign thermal_trip_n = !trip_req;
endmodule

//--- test/ppss_props.sv
// checker: concurrent properties on the sequencer ports
`timescale 1ns/1ps
module ppss_props
   import ppss_pkg::*;
#(
   parameter int unsigned RSM_CYC = RSM_HOLD_CYC
) (
   // clock and reset
   input wire logic       clock,
   input wire logic       sys_rst,
   // watched inputs
   input wire logic       resume_supplies_valid,
   input wire logic       junction_hot,
   input wire logic       over_temp_evt,
   input wire logic [3:0] irq_mask,
   input wire logic [3:0] irq_clear,
   input wire logic       thermal_trip_n,
   input wire logic       reset_ready_n,
   // watched outputs
   input wire logic       resume_domain_reset_n,
   input wire logic       supplies_good,
   input wire logic       processor_reset_n,
   input wire logic       reset_warning,
   input wire logic       irq_n_out,
   input wire logic       irq_n_oe,
   input wire logic       processor_hot_n_oe,
   input wire logic       platform_power_on,
   input wire logic [3:0] irq_status
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   // cycles of valid resume supplies, saturating
   logic [CNT_W-1:0] vcnt_ff;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         vcnt_ff <= CNT_RST;
      else if (!resume_supplies_valid)
         vcnt_ff <= CNT_RST;
      else if (~&vcnt_ff)
         vcnt_ff <= vcnt_ff + 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_rsm; $rose(resume_domain_reset_n) |-> vcnt_ff >= RSM_CYC - 1; endproperty
   a_rsm: assert property (p_rsm) else $error("resume reset released early");
   property p_rst; !resume_domain_reset_n |-> !supplies_good && !processor_reset_n; endproperty
   a_rst: assert property (p_rst) else $error("processor out of reset too soon");
   property p_irq; over_temp_evt |=> irq_status[0] && (irq_n_oe || irq_mask[0]); endproperty
   a_irq: assert property (p_irq) else $error("temp event not pending");
   property p_clr; irq_clear[0] && !over_temp_evt |=> !irq_status[0]; endproperty
   a_clr: assert property (p_clr) else $error("pending bit not cleared");
   property p_od; (irq_n_oe == |(irq_status & ~irq_mask)) && !irq_n_out; endproperty
   a_od: assert property (p_od) else $error("interrupt pin not following pending bits");
   property p_hot; junction_hot |=> processor_hot_n_oe; endproperty
   a_hot: assert property (p_hot) else $error("hot output not asserted");
   property p_hold; $fell(junction_hot) |-> processor_hot_n_oe [*8]; endproperty
   a_hold: assert property (p_hold) else $error("hot output released early");
   property p_trip; $fell(thermal_trip_n) |-> ##[1:4] !platform_power_on; endproperty
   a_trip: assert property (p_trip) else $error("power kept after trip");
   property p_rdy; reset_warning && !reset_ready_n |-> ##[1:4] !reset_warning; endproperty
   a_rdy: assert property (p_rdy) else $error("warning kept after ready");
endmodule

bind ppss_top ppss_props #(.RSM_CYC(RSM_CYC)) ppss_props_i (
   .clock(clock), .sys_rst(sys_rst), .resume_supplies_valid(resume_supplies_valid),
   .junction_hot(junction_hot), .over_temp_evt(over_temp_evt), .irq_mask(irq_mask),
   .irq_clear(irq_clear), .thermal_trip_n(thermal_trip_n), .reset_ready_n(reset_ready_n),
   .resume_domain_reset_n(resume_domain_reset_n), .supplies_good(supplies_good),
   .processor_reset_n(processor_reset_n), .reset_warning(reset_warning), .irq_n_out(irq_n_out),
   .irq_n_oe(irq_n_oe), .processor_hot_n_oe(processor_hot_n_oe),
   .platform_power_on(platform_power_on), .irq_status(irq_status));

//--- test/ppss_top_test.sv
// testbench: scenario tasks for the power state sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c) repeat (3000) if (!(c)) begin @(posedge clock); #1; end
module ppss_top_test;
   import ppss_pkg::*;
   localparam int DEB = 10;
   localparam int RSM = 20;
   logic clock = 0, sys_rst = 1, rv = 0, ms = 0, hs = 0, jh = 0, pbe = 1, pb_n = 1, wk_n = 1;
   logic ri_n = 1, sts = 0, slow = 0, trip = 0, htp = 0, hrdy = 1, rr_n, sr_n, hpe, tt_n;
   logic [2:0] evt = 3'h0;
   logic [3:0] msk = 4'h0, clr = 4'h0, ist;
   logic [6:0] vc = 7'h00, cvc, gvc;
   logic [1:0] vds = 2'h0;
   logic [2:0] pm;
   logic prn, sg, rsn, rw, ion, ioe, hon, hoe, mio, par, pbr, pcr, pbs, pcs, hsg, ppo;
   int n_fail = 0, samples_checked = 0;
   ppss_top #(.RSM_CYC(RSM), .DEB_CYC(DEB), .HOT_CYC(10)) ppss_top_i (
      .clock(clock), .sys_rst(sys_rst), .hub_variant_third_party(htp), .push_button_enable(pbe),
      .resume_supplies_valid(rv), .main_supplies_stable(ms), .hub_supplies_stable(hs), .junction_hot(jh),
      .over_temp_evt(evt[0]), .under_volt_evt(evt[1]), .over_volt_evt(evt[2]), .irq_mask(msk),
      .irq_clear(clr), .power_button_n(pb_n), .wake_n(wk_n), .reset_in_n(ri_n), .sleep_type_select(sts),
      .sleep_ready_n(sr_n), .reset_ready_n(rr_n), .hub_power_ok_enable(hpe), .thermal_trip_n(tt_n),
      .voltage_code(vc), .voltage_code_domain_select(vds), .processor_reset_n(prn), .supplies_good(sg),
      .resume_domain_reset_n(rsn), .reset_warning(rw), .irq_n_out(ion), .irq_n_oe(ioe),
      .processor_hot_n_out(hon), .processor_hot_n_oe(hoe), .power_mode_bus(pm), .memory_io_switch_ctrl(mio),
      .hub_plane_a_reset_n(par), .hub_plane_b_reset_n(pbr), .hub_plane_c_reset_n(pcr),
      .hub_plane_b_sleep_n(pbs), .hub_plane_c_sleep_n(pcs), .hub_supplies_good(hsg),
      .platform_power_on(ppo), .irq_status(ist), .core_voltage_code(cvc), .graphics_voltage_code(gvc));
   ppss_cpu_model ppss_cpu_model_i (
      .clock(clock), .sys_rst(sys_rst), .reset_warning(rw), .supplies_good(sg), .hub_ready(hrdy),
      .slow(slow), .trip_req(trip), .reset_ready_n(rr_n), .sleep_ready_n(sr_n),
      .hub_power_ok_enable(hpe), .thermal_trip_n(tt_n));
   ////////////////////////////////////////////////////////////////////////////
   task final_report;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task pulse_pin(input int which, input int len);
      @(posedge clock) if (which == 0) wk_n <= 0; else if (which == 1) pb_n <= 0; else ri_n <= 0;
      repeat (len) @(posedge clock);
      {wk_n, pb_n, ri_n} <= 3'h7;
   endtask
   task t_boot;
      int n;
      @(posedge clock) {rv, ms, hs} <= 3'h7;
      for (n = 0; n < 3000 && rsn !== 1'b1; n++) begin @(posedge clock); #1; end
      `CHK(n >= RSM - 1, 1'b1)
      `WAIT(par === 1'b1)
      `CHK(par, 1'b1)
      `CHK({sg, prn, mio}, 3'h0)
   endtask
   task t_wake(input logic tp);
      @(posedge clock) {htp, hrdy} <= {tp, !tp};
      pulse_pin(0, DEB / 2);
      repeat (40) @(posedge clock);
      #1 `CHK(sg, 1'b0)
      pulse_pin(0, DEB + 3);
      // third-party hub: run-up must stall until the hub grants it
      if (tp) begin
         repeat (40) @(posedge clock);
         #1 `CHK({sg, pm}, {1'b0, PM_COLD_DEF})
         @(posedge clock) hrdy <= 1'b1;
      end
      `WAIT(sg === 1'b1)
      `CHK({sg, prn, mio, hsg, pcr, pcs}, 6'h3f)
      `CHK(pm, PM_RUN_DEF)
   endtask
   task t_s0;
      pulse_pin(0, DEB + 3);
      repeat (40) @(posedge clock);
      #1 `CHK({sg, pm}, {1'b1, PM_RUN_DEF})
      pulse_pin(2, DEB + 3);
      `WAIT(pm === PM_WARM_DEF)
      `CHK({pm, prn}, {PM_WARM_DEF, 1'b0})
      `WAIT(pm === PM_RUN_DEF && prn === 1'b1)
      `CHK({pm, sg}, {PM_RUN_DEF, 1'b1})
   endtask
   task t_sleep(input logic st, input logic m);
      @(posedge clock) {sts, slow, msk[0], evt[0]} <= {st, st, m, 1'b1};
      @(posedge clock) evt[0] <= 1'b0;
      #1 `CHK({ist[0], ioe}, {1'b1, !m})
      // warning follows one cycle after the request is latched
      @(posedge clock);
      #1 `CHK(rw, 1'b1)
      `WAIT(sg === 1'b0)
      `CHK({rw, mio, pcr, pbr}, {3'h0, st})
      `CHK({pcs, pbs}, {1'b0, st})
      @(posedge clock) clr <= 4'h1;
      @(posedge clock) clr <= 4'h0;
      #1 `CHK({ist[0], ioe}, 2'h0)
   endtask
   task t_button;
      pulse_pin(1, DEB + 3);
      `WAIT(sg === 1'b1)
      `CHK({ist[3], ioe, ion}, 3'h6)
      @(posedge clock) clr <= 4'h8;
      @(posedge clock) clr <= 4'h0;
      #1 `CHK(ist, 4'h0)
   endtask
   task t_irq;
      for (int i = 1; i < 3; i++) begin
         @(posedge clock) evt[i] <= 1'b1;
         @(posedge clock) evt[i] <= 1'b0;
         #1 `CHK({ist[i], ioe}, 2'h3)
         @(posedge clock) clr[i] <= 1'b1;
         @(posedge clock) clr[i] <= 1'b0;
         #1 `CHK(ist[i], 1'b0)
      end
      // a press in S4/5 runs up but raises no interrupt
      pulse_pin(1, DEB + 3);
      repeat (4) @(posedge clock);
      #1 `CHK(ist[3], 1'b0)
      `WAIT(sg === 1'b1)
      `CHK(sg, 1'b1)
   endtask
   task t_hot_vid;
      @(posedge clock) {jh, vc, vds} <= {1'b1, 7'h55, 2'h1};
      repeat (3) @(posedge clock);
      jh <= 1'b0;
      {vc, vds} <= {7'h2a, 2'h2};
      repeat (9) @(posedge clock);
      #1 `CHK({hoe, hon}, 2'h2)
      `CHK(cvc, 7'h55)
      repeat (10) @(posedge clock);
      #1 `CHK({hoe, gvc}, {1'b0, 7'h2a})
   endtask
   task t_trip;
      @(posedge clock) trip <= 1'b1;
      repeat (6) @(posedge clock);
      trip <= 1'b0;
      repeat (20) @(posedge clock);
      #1 `CHK({ppo, sg}, 2'h0)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial forever #2.5 clock = ~clock;
   initial begin
      #100000;
      n_fail++;
      final_report;
   end
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      t_boot;
      t_wake(1'b0);
      t_hot_vid;
      t_s0;
      t_sleep(1'b1, 1'b0);
      t_button;
      t_sleep(1'b0, 1'b1);
      @(posedge clock) msk <= 4'h0;
      t_irq;
      t_sleep(1'b1, 1'b1);
      t_wake(1'b1);
      t_trip;
      final_report;
   end
endmodule
